// file: src/coproc_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef COPROC_DEFS_SVH
`define COPROC_DEFS_SVH
`define WORD_WIDTH 12
`define ADDR_WIDTH 4
`define PIN_COUNT 6
`define ADC_WIDTH 11
`define SHORT_WIDTH 7
`define WR_REVERSE_ANGLE 4'h0
`define WR_INPUT_1 4'h1
`define WR_INPUT_2 4'h2
`define WR_INPUT_3 4'h3
`define WR_FORWARD_ANGLE 4'h4
`define WR_PWM_PERIOD 4'h5
`define WR_PWM_ON_A 4'h6
`define WR_PWM_ON_B 4'h7
`define WR_PWM_ON_C 4'h8
`define WR_PWM_DEADTIME 4'h9
`define WR_PWM_DELETION 4'hA
`define WR_PIN_CONTROL 4'hB
`define WR_PIN_DATA 4'hC
`define WR_SYSTEM_CONTROL 4'hD
`define RD_RESULT_0 4'h0
`define RD_RESULT_1 4'h1
`define RD_RESULT_2 4'h2
`define RD_RESULT_3 4'h3
`define RD_ADC_V 4'h5
`define RD_ADC_W 4'h6
`define RD_ADC_AUX 4'h7
`define RD_ADC_U 4'h8
`define RD_PIN_DATA 4'hC
`define RD_SYSTEM_CONTROL 4'hD
`define RD_SYSTEM_STATUS 4'hE
`define CTRL_AUX_LO 0
`define CTRL_AUX_HI 1
`define CTRL_CONVERT_U 3
`define CTRL_CONVERT_AUX 4
`define CTRL_DIVIDE 5
`define CTRL_TRANSFORM_IE 6
`define CTRL_ADC_IE 7
`define CTRL_LEVEL_MODE 8
`define CTRL_THREE_PHASE 10
`define STAT_ADC 0
`define STAT_TRANSFORM 1
`define STAT_PIN 2
`define STAT_VALID 4
`define STAT_ANY 11
`define CONTROL_RESET 12'h000
`define PIN_CONTROL_RESET 12'h000
`define SYNC_STAGES 2
`endif

// file: src/coproc_pkg.sv
// Types shared by the host register port modules.
package coproc_pkg;
   typedef logic [11:0] word_t;
   typedef logic [3:0] addr_t;
   typedef logic [5:0] pins_t;
   typedef enum logic [1:0] {
      IRQ_IDLE = 2'b00,
      IRQ_PULSE = 2'b01,
      IRQ_HOLD = 2'b10
   } irq_state_t;
endpackage : coproc_pkg

// file: src/pin_port_if.sv
// Carrier between the register port and the digital pin port.
`timescale 1ns/100ps
interface pin_port_if;
   import coproc_pkg::*;
   logic data_write;
   word_t write_value;
   word_t control;
   pins_t read_value;
   logic change_event;
   modport regs (output data_write, output write_value, output control,
      input read_value, input change_event);
   modport port (input data_write, input write_value, input control,
      output read_value, output change_event);
endinterface : pin_port_if

// file: src/host_bus_sync.sv
// Synchroniser and strobe decoder for the host parallel bus pins.
`timescale 1ns/100ps
`include "coproc_defs.svh"
module host_bus_sync (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire coproc_pkg::addr_t i_addr,
   input wire coproc_pkg::word_t i_data,
   output logic o_write,
   output coproc_pkg::addr_t o_write_addr,
   output coproc_pkg::word_t o_write_data,
   output logic o_read_active,
   output logic o_read_end,
   output coproc_pkg::addr_t o_read_addr
);
   import coproc_pkg::*;
   logic [18:0] meta;
   logic [18:0] sync;
   logic [18:0] held;
   logic read_was;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta <= 19'h7FFFF;
         sync <= 19'h7FFFF;
         held <= 19'h7FFFF;
      end else begin
         meta <= {i_cs_n, i_rd_n, i_wr_n, i_addr, i_data};
         sync <= meta;
         held <= sync;
      end
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         read_was <= 1'b0;
      end else begin
         read_was <= o_read_active;
      end
   end
   // A write lands on the rising edge of the write strobe, using the
   // address and data seen while the strobe was still low.
   assign o_write = sync[16] && !held[16] && !held[18];
   assign o_write_addr = held[15:12];
   assign o_write_data = held[11:0];
   assign o_read_active = !sync[18] && !sync[17];
   assign o_read_end = read_was && !o_read_active;
   assign o_read_addr = sync[15:12];
endmodule : host_bus_sync

// file: src/pin_port.sv
// Six-bit digital pin port with direction control and change detection.
`timescale 1ns/100ps
`include "coproc_defs.svh"
module pin_port #(
   parameter int PINS = `PIN_COUNT
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [PINS-1:0] i_pins,
   output logic [PINS-1:0] o_pins,
   output logic [PINS-1:0] o_pins_oe,
   pin_port_if.port bus
);
   import coproc_pkg::*;
   logic [PINS-1:0] meta;
   logic [PINS-1:0] level;
   logic [PINS-1:0] level_was;
   logic [PINS-1:0] latch;
   logic [PINS-1:0] direction;
   logic [PINS-1:0] enable;
   logic [PINS-1:0] change;
   assign direction = bus.control[PINS-1:0];
   assign enable = bus.control[2*PINS-1:PINS];
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta <= '0;
         level <= '0;
         level_was <= '0;
      end else begin
         meta <= i_pins;
         level <= meta;
         level_was <= level;
      end
   end
   genvar g;
   for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            latch[g] <= 1'b0;
         end else if (bus.data_write && direction[g]) begin
            latch[g] <= bus.write_value[g];
         end
      end
      assign change[g] = (level[g] ^ level_was[g]) && enable[g]
         && !direction[g];
      assign bus.read_value[g] = direction[g] ? latch[g] : level[g];
      assign o_pins[g] = latch[g];
      assign o_pins_oe[g] = direction[g];
   end
   assign bus.change_event = |change;
endmodule : pin_port

// file: src/motion_coproc_host_register_port.sv
// Host register port of the motion coprocessor.
`timescale 1ns/100ps
`include "coproc_defs.svh"
module motion_coproc_host_register_port (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire coproc_pkg::addr_t i_addr,
   input wire coproc_pkg::word_t i_data,
   output coproc_pkg::word_t o_data,
   output logic o_data_oe,
   output logic o_irq_n,
   output logic o_irq_n_oe,
   input wire coproc_pkg::pins_t i_pins,
   output coproc_pkg::pins_t o_pins,
   output coproc_pkg::pins_t o_pins_oe,
   output logic o_sys_tick,
   output logic o_reverse_start,
   output logic o_forward_start,
   output coproc_pkg::word_t o_reverse_angle,
   output coproc_pkg::word_t o_forward_angle,
   output coproc_pkg::word_t o_reverse_input_1,
   output coproc_pkg::word_t o_reverse_input_2,
   output coproc_pkg::word_t o_reverse_input_3,
   output coproc_pkg::word_t o_pwm_period,
   output coproc_pkg::word_t o_pwm_on_time_a,
   output coproc_pkg::word_t o_pwm_on_time_b,
   output coproc_pkg::word_t o_pwm_on_time_c,
   output logic [6:0] o_pwm_deadtime,
   output logic [6:0] o_pwm_pulse_deletion,
   output logic [1:0] o_aux_select,
   output logic o_convert_u,
   output logic o_convert_aux,
   output logic o_reverse_three_phase,
   input wire logic i_transform_done,
   input wire logic i_adc_done,
   input wire coproc_pkg::word_t i_result_0,
   input wire coproc_pkg::word_t i_result_1,
   input wire coproc_pkg::word_t i_result_2,
   input wire coproc_pkg::word_t i_result_3,
   input wire logic [10:0] i_adc_v,
   input wire logic [10:0] i_adc_w,
   input wire logic [10:0] i_adc_aux,
   input wire logic [10:0] i_adc_u
);
   import coproc_pkg::*;

   logic write;
   addr_t write_addr;
   word_t write_data;
   logic read_active;
   logic read_end;
   addr_t read_addr;
   word_t system_control;
   word_t pin_port_control;
   logic stat_adc;
   logic stat_transform;
   logic stat_pin;
   logic stat_any;
   logic stat_valid;
   logic status_cleared;
   logic event_adc;
   logic event_transform;
   logic event_pin;
   logic event_any;
   logic tick_phase;
   logic pulse_left;
   irq_state_t irq_state;
   irq_state_t next_irq_state;
   word_t next_read_data;
   word_t status_word;

   pin_port_if pin_bus ();

   host_bus_sync u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_cs_n(i_cs_n),
      .i_rd_n(i_rd_n),
      .i_wr_n(i_wr_n),
      .i_addr(i_addr),
      .i_data(i_data),
      .o_write(write),
      .o_write_addr(write_addr),
      .o_write_data(write_data),
      .o_read_active(read_active),
      .o_read_end(read_end),
      .o_read_addr(read_addr)
   );

   pin_port #(
      .PINS(`PIN_COUNT)
   ) u_pins (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_pins(i_pins),
      .o_pins(o_pins),
      .o_pins_oe(o_pins_oe),
      .bus(pin_bus.port)
   );

   // Transform operand and angle registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_reverse_angle <= '0;
         o_forward_angle <= '0;
         o_reverse_input_1 <= '0;
         o_reverse_input_2 <= '0;
         o_reverse_input_3 <= '0;
      end else if (write) begin
         case (write_addr)
            `WR_REVERSE_ANGLE: begin
               o_reverse_angle <= write_data;
            end
            `WR_INPUT_1: begin
               o_reverse_input_1 <= write_data;
            end
            `WR_INPUT_2: begin
               o_reverse_input_2 <= write_data;
            end
            `WR_INPUT_3: begin
               o_reverse_input_3 <= write_data;
            end
            `WR_FORWARD_ANGLE: begin
               o_forward_angle <= write_data;
            end
            default: begin
            end
         endcase
      end
   end

   // Start strobes are one clock wide and rise in the same clock as the angle load.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_reverse_start <= 1'b0;
         o_forward_start <= 1'b0;
      end else begin
         o_reverse_start <= write && write_addr == `WR_REVERSE_ANGLE;
         o_forward_start <= write && write_addr == `WR_FORWARD_ANGLE;
      end
   end

   // Timer setting registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pwm_period <= '0;
         o_pwm_on_time_a <= '0;
         o_pwm_on_time_b <= '0;
         o_pwm_on_time_c <= '0;
         o_pwm_deadtime <= '0;
         o_pwm_pulse_deletion <= '0;
      end else if (write) begin
         case (write_addr)
            `WR_PWM_PERIOD: begin
               o_pwm_period <= write_data;
            end
            `WR_PWM_ON_A: begin
               o_pwm_on_time_a <= write_data;
            end
            `WR_PWM_ON_B: begin
               o_pwm_on_time_b <= write_data;
            end
            `WR_PWM_ON_C: begin
               o_pwm_on_time_c <= write_data;
            end
            `WR_PWM_DEADTIME: begin
               o_pwm_deadtime <= write_data[6:0];
            end
            `WR_PWM_DELETION: begin
               o_pwm_pulse_deletion <= write_data[6:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Control registers; reserved locations 14 and 15 change nothing.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         system_control <= `CONTROL_RESET;
         pin_port_control <= `PIN_CONTROL_RESET;
      end else if (write) begin
         if (write_addr == `WR_SYSTEM_CONTROL) begin
            system_control <= write_data;
         end
         if (write_addr == `WR_PIN_CONTROL) begin
            pin_port_control <= write_data;
         end
      end
   end

   assign pin_bus.control = pin_port_control;
   assign pin_bus.write_value = write_data;
   assign pin_bus.data_write = write && write_addr == `WR_PIN_DATA;

   assign o_aux_select = {system_control[`CTRL_AUX_LO],
      system_control[`CTRL_AUX_HI]};
   assign o_convert_u = system_control[`CTRL_CONVERT_U];
   assign o_convert_aux = system_control[`CTRL_CONVERT_AUX];
   assign o_reverse_three_phase = system_control[`CTRL_THREE_PHASE];

   // System clock enable: every clock, or every second one when halved.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tick_phase <= 1'b0;
      end else begin
         tick_phase <= !tick_phase && system_control[`CTRL_DIVIDE];
      end
   end
   assign o_sys_tick = !tick_phase;

   // Interrupt sources, gated by their enables.
   assign event_adc = i_adc_done && system_control[`CTRL_ADC_IE];
   assign event_transform = i_transform_done
      && system_control[`CTRL_TRANSFORM_IE];
   assign event_pin = pin_bus.change_event;
   assign event_any = event_adc || event_transform || event_pin;
   assign status_cleared = read_end && read_addr == `RD_SYSTEM_STATUS;

   // Sticky status flags; a new event wins over a clearing read.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stat_adc <= 1'b0;
         stat_transform <= 1'b0;
         stat_pin <= 1'b0;
         stat_any <= 1'b0;
      end else begin
         stat_adc <= event_adc || (stat_adc && !status_cleared);
         stat_transform <= event_transform
            || (stat_transform && !status_cleared);
         stat_pin <= event_pin || (stat_pin && !status_cleared);
         stat_any <= event_any || (stat_any && !status_cleared);
      end
   end

   // Results go invalid when a transform starts and valid when it ends.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stat_valid <= 1'b0;
      end else if (i_transform_done) begin
         stat_valid <= 1'b1;
      end else if (o_reverse_start || o_forward_start) begin
         stat_valid <= 1'b0;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[`STAT_ADC] = stat_adc;
      status_word[`STAT_TRANSFORM] = stat_transform;
      status_word[`STAT_PIN] = stat_pin;
      status_word[`STAT_VALID] = stat_valid;
      status_word[`STAT_ANY] = stat_any;
   end

   // Request line state: edge pulse lasts one system clock.
   always_comb begin
      next_irq_state = irq_state;
      case (irq_state)
         IRQ_IDLE: begin
            if (event_any && system_control[`CTRL_LEVEL_MODE]) begin
               next_irq_state = IRQ_HOLD;
            end else if (event_any) begin
               next_irq_state = IRQ_PULSE;
            end
         end
         IRQ_PULSE: begin
            if (!pulse_left) begin
               next_irq_state = IRQ_IDLE;
            end
         end
         IRQ_HOLD: begin
            if (status_cleared && !event_any) begin
               next_irq_state = IRQ_IDLE;
            end
         end
         default: begin
            next_irq_state = IRQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         irq_state <= IRQ_IDLE;
      end else begin
         irq_state <= next_irq_state;
      end
   end

   // A halved system clock makes the pulse two clocks long.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pulse_left <= 1'b0;
      end else if (irq_state == IRQ_IDLE) begin
         pulse_left <= system_control[`CTRL_DIVIDE];
      end else begin
         pulse_left <= 1'b0;
      end
   end

   assign o_irq_n = 1'b0;
   assign o_irq_n_oe = irq_state != IRQ_IDLE;

   // Read multiplexer; reserved locations read as zero.
   always_comb begin
      case (read_addr)
         `RD_RESULT_0: next_read_data = i_result_0;
         `RD_RESULT_1: next_read_data = i_result_1;
         `RD_RESULT_2: next_read_data = i_result_2;
         `RD_RESULT_3: next_read_data = i_result_3;
         `RD_ADC_V: next_read_data = {i_adc_v, 1'b0};
         `RD_ADC_W: next_read_data = {i_adc_w, 1'b0};
         `RD_ADC_AUX: next_read_data = {i_adc_aux, 1'b0};
         `RD_ADC_U: next_read_data = {i_adc_u, 1'b0};
         `RD_PIN_DATA: next_read_data = {6'h00, pin_bus.read_value};
         `RD_SYSTEM_CONTROL: next_read_data = system_control;
         `RD_SYSTEM_STATUS: next_read_data = status_word;
         default: next_read_data = '0;
      endcase
   end

   // Data bus is driven from one clock after a read is seen until one clock after it ends.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_data <= '0;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= read_active;
         if (read_active) begin
            o_data <= next_read_data;
         end
      end
   end
endmodule : motion_coproc_host_register_port

// file: tb/coproc_port_chk.sv
// Concurrent checks on the pins of the host register port.
`timescale 1ns/100ps
module coproc_port_chk (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire coproc_pkg::addr_t i_addr,
   input wire coproc_pkg::pins_t i_pins,
   input wire logic i_transform_done,
   input wire logic i_adc_done,
   input wire coproc_pkg::word_t o_data,
   input wire logic o_data_oe,
   input wire logic o_irq_n,
   input wire logic o_irq_n_oe,
   input wire coproc_pkg::pins_t o_pins_oe,
   input wire logic o_sys_tick,
   input wire logic o_reverse_start,
   input wire logic o_forward_start,
   input wire coproc_pkg::word_t o_reverse_angle,
   input wire coproc_pkg::word_t o_forward_angle
);
   import coproc_pkg::*;
   logic [2:0] quiet;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         quiet <= 3'h7;
      end else if (i_pins != $past(i_pins)) begin
         quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
         quiet <= quiet + 3'h1;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence pulse_s(sig);
      sig ##1 !sig;
   endsequence
   sequence done_s;
      $past(i_transform_done || i_adc_done) ||
         $past(i_transform_done || i_adc_done, 2);
   endsequence
   rev_start_a: assert property (
      $changed(o_reverse_angle) |-> pulse_s(o_reverse_start))
      else $error("reverse start pulse missing");
   fwd_start_a: assert property (
      $changed(o_forward_angle) |-> pulse_s(o_forward_start))
      else $error("forward start pulse missing");
   read_drive_a: assert property (
      $rose(o_data_oe) |-> $past(!i_cs_n && !i_rd_n, 2))
      else $error("data driven without a read");
   read_release_a: assert property (
      i_rd_n [*5] |-> !o_data_oe)
      else $error("data bus still driven after read");
   rsvd_read_a: assert property (
      o_data_oe && !i_rd_n && $past(!i_rd_n, 4) &&
         i_addr == $past(i_addr, 4) &&
         i_addr inside {4'h4, 4'h9, 4'hA, 4'hB, 4'hF} |-> o_data == 12'h000)
      else $error("reserved read not zero");
   irq_drain_a: assert property (
      o_irq_n_oe |-> o_irq_n == 1'b0)
      else $error("request line driven high");
   sys_tick_a: assert property (
      !o_sys_tick |=> o_sys_tick)
      else $error("system tick missed");
   pin_dir_a: assert property (
      $changed(o_pins_oe) |-> $past(i_wr_n, 2) &&
         !($past(i_wr_n, 4) && $past(i_wr_n, 5) && $past(i_wr_n, 6)))
      else $error("pin direction changed without write");
   irq_cause_a: assert property (
      $rose(o_irq_n_oe) |-> done_s or quiet < 3'h6)
      else $error("request without an event");
endmodule : coproc_port_chk
bind motion_coproc_host_register_port coproc_port_chk u_chk (.i_clock,
   .i_rst, .i_cs_n, .i_rd_n, .i_wr_n, .i_addr, .i_pins, .i_transform_done,
   .i_adc_done, .o_data, .o_data_oe, .o_irq_n, .o_irq_n_oe, .o_pins_oe,
   .o_sys_tick, .o_reverse_start, .o_forward_start, .o_reverse_angle,
   .o_forward_angle);

// file: tb/host_model.sv
// Host processor model that drives the parallel register bus.
`timescale 1ns/100ps
module host_model (
   input wire logic i_clock,
   input wire coproc_pkg::word_t i_data,
   input wire logic i_data_oe,
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_wr_n,
   output coproc_pkg::addr_t o_addr,
   output coproc_pkg::word_t o_data
);
   import coproc_pkg::*;
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_addr = 4'h0;
      o_data = 12'h000;
   end
   task automatic wr(input addr_t a, input word_t v);
      o_cs_n <= 1'b0;
      o_wr_n <= 1'b0;
      o_addr <= a;
      o_data <= v;
      repeat (4) @(posedge i_clock);
      o_wr_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_cs_n <= 1'b1;
      o_data <= ~v;
      repeat (2) @(posedge i_clock);
   endtask : wr
   task automatic wr_unsel(input addr_t a, input word_t v);
      o_addr <= a;
      o_data <= v;
      o_wr_n <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_wr_n <= 1'b1;
      repeat (6) @(posedge i_clock);
   endtask : wr_unsel
   task automatic rd(input addr_t a, output word_t v, output logic ok);
      o_cs_n <= 1'b0;
      o_rd_n <= 1'b0;
      o_addr <= a;
      o_data <= ~o_data;
      repeat (6) @(posedge i_clock);
      @(negedge i_clock);
      ok = i_data_oe;
      v = i_data;
      @(posedge i_clock);
      o_rd_n <= 1'b1;
      o_cs_n <= 1'b1;
      repeat (5) @(posedge i_clock);
   endtask : rd
endmodule : host_model

// file: tb/testbench.sv
// Self-checking bench for the host register port.
`timescale 1ns/100ps
module testbench;
   import coproc_pkg::*;
   logic i_clock, i_rst, i_cs_n, i_rd_n, i_wr_n, o_data_oe, o_irq_n;
   logic o_irq_n_oe, o_sys_tick, o_reverse_start, o_forward_start;
   logic o_convert_u, o_convert_aux, o_reverse_three_phase;
   logic i_transform_done, i_adc_done;
   addr_t i_addr;
   word_t i_data, o_data, o_reverse_angle, o_forward_angle, o_pwm_period;
   word_t o_reverse_input_1, o_reverse_input_2, o_reverse_input_3;
   word_t o_pwm_on_time_a, o_pwm_on_time_b, o_pwm_on_time_c, d;
   word_t i_result_0, i_result_1, i_result_2, i_result_3;
   logic [10:0] i_adc_v, i_adc_w, i_adc_aux, i_adc_u;
   logic [6:0] o_pwm_deadtime, o_pwm_pulse_deletion;
   logic [1:0] o_aux_select;
   pins_t i_pins, o_pins, o_pins_oe, ext_pins;
   int error_cnt, n_checks, irq_cyc, rev_cnt, fwd_cnt;
   motion_coproc_host_register_port u_dut (.*);
   host_model u_host (.i_clock, .i_data(o_data), .i_data_oe(o_data_oe),
      .o_cs_n(i_cs_n), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr),
      .o_data(i_data));
   assign i_pins = (o_pins & o_pins_oe) | (ext_pins & ~o_pins_oe);
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      irq_cyc <= irq_cyc + int'(o_irq_n_oe === 1'b1);
      rev_cnt <= rev_cnt + int'(o_reverse_start === 1'b1);
      fwd_cnt <= fwd_cnt + int'(o_forward_start === 1'b1);
   end
   task automatic check(input word_t got, input word_t exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input addr_t a, input word_t exp);
      logic ok;
      u_host.rd(a, d, ok);
      check(ok === 1'b1 ? d : ~exp, exp);
   endtask : rd_chk
   task automatic pulse(input logic adc);
      i_adc_done <= adc;
      i_transform_done <= ~adc;
      @(posedge i_clock);
      i_adc_done <= 1'b0;
      i_transform_done <= 1'b0;
      repeat (6) @(posedge i_clock);
   endtask : pulse
   function automatic word_t wv(input int a);
      return word_t'(a) * 12'h123 + 12'h0A5;
   endfunction : wv
   task automatic test_write_map;
      int r0;
      int f0;
      r0 = rev_cnt;
      f0 = fwd_cnt;
      u_host.wr(4'hD, 12'h420);
      u_host.wr(4'h0, 12'h200);
      u_host.wr(4'h4, 12'h400);
      for (int a = 1; a <= 10; a++) begin
         if (a != 4) begin
            u_host.wr(4'(a), wv(a));
         end
      end
      check(word_t'(rev_cnt - r0), 12'h001);
      check(word_t'(fwd_cnt - f0), 12'h001);
      check(o_reverse_angle, 12'h200);
      check(o_forward_angle, 12'h400);
      check(o_reverse_input_1, wv(1));
      check(o_reverse_input_2, wv(2));
      check(o_reverse_input_3, wv(3));
      check(o_pwm_period, wv(5));
      check(o_pwm_on_time_a, wv(6));
      check(o_pwm_on_time_b, wv(7));
      check(o_pwm_on_time_c, wv(8));
      check({5'h00, o_pwm_deadtime}, wv(9) & 12'h07F);
      check({5'h00, o_pwm_pulse_deletion}, wv(10) & 12'h07F);
   endtask : test_write_map
   task automatic test_read_map;
      addr_t rsv[5] = '{4'h4, 4'h9, 4'hA, 4'hB, 4'hF};
      {i_result_0, i_result_1, i_result_2, i_result_3} <=
         {12'h123, 12'h456, 12'h789, 12'hABC};
      {i_adc_v, i_adc_w, i_adc_aux, i_adc_u} <=
         {11'h5A5, 11'h2D3, 11'h7FF, 11'h401};
      @(posedge i_clock);
      rd_chk(4'h0, 12'h123);
      rd_chk(4'h1, 12'h456);
      rd_chk(4'h2, 12'h789);
      rd_chk(4'h3, 12'hABC);
      rd_chk(4'h5, 12'hB4A);
      rd_chk(4'h6, 12'h5A6);
      rd_chk(4'h7, 12'hFFE);
      rd_chk(4'h8, 12'h802);
      foreach (rsv[i]) begin
         rd_chk(rsv[i], 12'h000);
      end
      u_host.wr(4'hE, 12'hFFF);
      u_host.wr(4'hF, 12'hFFF);
      u_host.wr_unsel(4'hD, 12'h000);
      rd_chk(4'hD, 12'h420);
      rd_chk(4'hE, 12'h000);
   endtask : test_read_map
   task automatic test_control;
      word_t c;
      logic t;
      for (int i = 0; i < 4; i++) begin
         c = 12'h420 | word_t'(i) | (word_t'(i) << 3);
         u_host.wr(4'hD, c);
         check({10'h000, o_aux_select}, {10'h000, c[0], c[1]});
         check({10'h000, o_convert_u, o_convert_aux},
            {10'h000, c[3], c[4]});
         rd_chk(4'hD, c);
      end
      check({11'h000, o_reverse_three_phase}, 12'h001);
      @(negedge i_clock);
      t = o_sys_tick;
      @(negedge i_clock);
      check({11'h000, t ^ o_sys_tick}, 12'h001);
      @(posedge i_clock);
   endtask : test_control
   task automatic test_irq;
      int c0;
      u_host.wr(4'hD, 12'h4C0);
      check({11'h000, o_sys_tick}, 12'h001);
      c0 = irq_cyc;
      pulse(1'b1);
      check(word_t'(irq_cyc - c0), 12'h001);
      rd_chk(4'hE, 12'h801);
      u_host.wr(4'hD, 12'h4E0);
      c0 = irq_cyc;
      pulse(1'b1);
      check(word_t'(irq_cyc - c0), 12'h002);
      rd_chk(4'hE, 12'h801);
      rd_chk(4'hE, 12'h000);
      pulse(1'b0);
      rd_chk(4'hE, 12'h812);
      u_host.wr(4'hD, 12'h420);
      c0 = irq_cyc;
      pulse(1'b1);
      pulse(1'b0);
      check(word_t'(irq_cyc - c0), 12'h000);
      rd_chk(4'hE, 12'h010);
      u_host.wr(4'hD, 12'h5E0);
      pulse(1'b0);
      repeat (20) @(posedge i_clock);
      check({11'h000, o_irq_n_oe}, 12'h001);
      rd_chk(4'hE, 12'h812);
      check({11'h000, o_irq_n_oe}, 12'h000);
   endtask : test_irq
   task automatic test_pins;
      u_host.wr(4'hD, 12'h420);
      u_host.wr(4'hB, 12'hFCF);
      u_host.wr(4'hC, 12'hFFF);
      check({6'h00, o_pins_oe}, 12'h00F);
      check({6'h00, o_pins}, 12'h00F);
      rd_chk(4'hE, 12'h010);
      ext_pins <= 6'h10;
      repeat (8) @(posedge i_clock);
      rd_chk(4'hE, 12'h814);
      rd_chk(4'hE, 12'h010);
      rd_chk(4'hC, 12'h01F);
   endtask : test_pins
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      #400000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      i_rst = 1'b1;
      i_adc_done = 1'b0;
      i_transform_done = 1'b0;
      ext_pins = 6'h00;
      {i_result_0, i_result_1, i_result_2, i_result_3} = '0;
      {i_adc_v, i_adc_w, i_adc_aux, i_adc_u} = '0;
      repeat (8) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      check({6'h00, o_pins_oe}, 12'h000);
      check({11'h000, o_sys_tick}, 12'h001);
      rd_chk(4'hD, 12'h000);
      rd_chk(4'hE, 12'h000);
      test_write_map();
      test_read_map();
      test_control();
      test_irq();
      test_pins();
      summarize();
   end
endmodule : testbench
